/* File: rtl/lbcs_consts.svh */
`ifndef LBCS_CONSTS_SVH
`define LBCS_CONSTS_SVH
// Overview of operation
// - With no transfer in progress the bus sits in the idle state.
// - A request taken while idle moves the bus to address state, driving the address.
// - After address, enter data state and move a word only when ready is asserted.
// - Without ready, wait states repeat without limit; the responder must eventually assert ready.
// - A single-word transfer goes to recovery once its word has moved.
// - A burst returns to the data state after each word, one word per clock at most.
// - After the last word of a burst of up to four, enter recovery.
// - After recovery go idle if nothing waits, else straight to address state.
// - Address and data share one set of 32 lines, multiplexed by bus state.
// - Four byte enables with bursts of up to four words give 1 to 16 bytes.
// - I/O is reached through memory addresses with 8, 16 and 32 bit transfers.
// - The sequence assumes one bus master owns the bus.
// - Address state low two lines carry word count minus one.
// - Address strobe asserts in every address state and after each ready within bursts.
// - Four active-low byte enables name the active byte lanes.
`define LBCS_DATA_WIDTH 32
`define LBCS_MAX_WORDS 4
`define LBCS_SIZE_POS 0
`define LBCS_STROBE_IDLE 1'b1
`define LBCS_LANES_IDLE 4'hf
`endif

/* File: rtl/lbcs_pkg.sv */
package lbcs_pkg;
  typedef enum logic [2:0] {
    IDLE_STATE,
    ADDRESS_PHASE_STATE,
    DATA_PHASE_STATE,
    WAIT_PHASE_STATE,
    RECOVERY_STATE
  } lbcs_state_type;
endpackage

/* File: rtl/lbcs_sequencer.sv */
`include "lbcs_consts.svh"
// Bus cycle sequencer for the multiplexed 32-bit local bus, single master only.
// Each bus state lasts one clock; the pins are registered copies of what the
// state being entered needs, so no pin glitches between states.
module lbcs_sequencer #(
  parameter int WORDS = `LBCS_MAX_WORDS
) (
  input wire logic core_clk,
  input wire logic srst,
  // Transfer request from the core.
  input wire logic reqValid,
  output logic reqReady,
  input wire logic reqWrite,
  input wire logic [29:0] reqWordAddr,
  input wire logic [1:0] reqSizeCode,
  input wire logic [15:0] reqByteEnables,
  input wire logic [127:0] reqWriteData,
  // Read words back to the core through the buffer.
  output logic rdValid,
  input wire logic rdReady,
  output logic [31:0] rdData,
  // Bus pins.
  input wire logic [31:0] sharedAddrDataIn,
  output logic [31:0] sharedAddrDataOut,
  output logic sharedAddrDataOe,
  output logic addressStrobe_n,
  output logic [3:0] byteLaneEnable_n,
  output logic writeNotRead,
  output logic dataEnable_n,
  input wire logic ready_n,
  output logic [2:0] busState
);
  // Bus state and the captured request.
  logic [2:0] state;
  logic [2:0] next_state;
  logic [1:0] wordIdx;
  logic [1:0] next_wordIdx;
  logic [1:0] lastIdx;
  logic [1:0] next_lastIdx;
  logic isWrite;
  logic next_isWrite;
  logic [29:0] addr;
  logic [29:0] next_addr;
  logic [15:0] bes;
  logic [15:0] next_bes;
  logic [127:0] wdata;
  logic [127:0] next_wdata;
  logic [31:0] next_out;
  logic next_oe;
  logic next_strobe_n;
  logic [3:0] next_lanes_n;
  logic next_den_n;
  logic next_reqReady;
  // Handshake between the bus side and the read buffer.
  logic wordDone;
  logic bufReady;
  logic pushRead;

  // Elaboration refuses a burst depth other than four words: the size code on the
  // two low address lines and the 16 lane enables cannot describe anything else.
  if (WORDS != `LBCS_MAX_WORDS) begin : g_wordsCheck
    $error("lbcs_sequencer: only four-word bursts are supported.");
  end

  // Returns the four lane enables for word i of a burst; the same lanes serve
  // 8, 16 and 32 bit accesses, so memory-mapped devices need nothing else.
  function automatic logic [3:0] pickLanes(input logic [15:0] all, input logic [1:0] i);
    pickLanes = all[{i, 2'b00} +: 4];
  endfunction

  // True in the states where a word may move on the shared lines.
  function automatic logic inDataPhase(input logic [2:0] s);
    inDataPhase = (s == lbcs_pkg::DATA_PHASE_STATE) || (s == lbcs_pkg::WAIT_PHASE_STATE);
  endfunction

  // True in the states from which a new request may be taken.
  function automatic logic canTake(input logic [2:0] s);
    canTake = (s == lbcs_pkg::IDLE_STATE) || (s == lbcs_pkg::RECOVERY_STATE);
  endfunction

  // A read word completes only when the buffer can take it, so a stalled
  // consumer stretches the bus with wait states rather than losing data.
  // The price is that a slow consumer also holds the bus away from writes.
  assign wordDone = !ready_n && (isWrite || bufReady);
  assign pushRead = inDataPhase(state) && wordDone && !isWrite;

  // Next state and the captured request; every state lasts one clock.
  always_comb begin
    next_state = state;
    next_wordIdx = wordIdx;
    next_lastIdx = lastIdx;
    next_isWrite = isWrite;
    next_addr = addr;
    next_bes = bes;
    next_wdata = wdata;
    case (lbcs_pkg::lbcs_state_type'(state))
      lbcs_pkg::IDLE_STATE: begin
        if (reqValid) begin
          next_state = lbcs_pkg::ADDRESS_PHASE_STATE;
        end
      end
      lbcs_pkg::ADDRESS_PHASE_STATE: begin
        // The address state never waits; ready is only looked at in data states.
        next_state = lbcs_pkg::DATA_PHASE_STATE;
      end
      lbcs_pkg::DATA_PHASE_STATE, lbcs_pkg::WAIT_PHASE_STATE: begin
        // A read that the buffer cannot take looks like a missing ready, so the
        // bus waits instead of dropping the word.
        if (!wordDone) begin
          next_state = lbcs_pkg::WAIT_PHASE_STATE;
        end else if (wordIdx == lastIdx) begin
          next_state = lbcs_pkg::RECOVERY_STATE;
        end else begin
          next_state = lbcs_pkg::DATA_PHASE_STATE;
          next_wordIdx = wordIdx + 2'd1;
        end
      end
      lbcs_pkg::RECOVERY_STATE: begin
        // Recovery always lasts one clock, even with a request already waiting.
        next_state = reqValid ? lbcs_pkg::ADDRESS_PHASE_STATE : lbcs_pkg::IDLE_STATE;
      end
      default: begin
        next_state = lbcs_pkg::IDLE_STATE;
      end
    endcase
    // Capture the request as the address state is entered.
    // The whole request is copied here so the core may change its inputs as soon
    // as it has been taken; later words read only these copies.
    if (reqReady && reqValid) begin
      next_isWrite = reqWrite;
      next_addr = reqWordAddr;
      next_lastIdx = reqSizeCode;
      next_bes = reqByteEnables;
      next_wdata = reqWriteData;
      next_wordIdx = 2'd0;
    end
  end

  // Pin values for the state being entered, so outputs come from flip-flops.
  // Idle and recovery release the shared lines and park every strobe high.
  always_comb begin
    next_out = '0;
    next_oe = 1'b0;
    next_strobe_n = `LBCS_STROBE_IDLE;
    next_lanes_n = `LBCS_LANES_IDLE;
    next_den_n = 1'b1;
    // Taking a request is decided from the state being entered, so the ready
    // output is a flop that agrees with the state register on every clock.
    next_reqReady = canTake(next_state);
    case (lbcs_pkg::lbcs_state_type'(next_state))
      lbcs_pkg::ADDRESS_PHASE_STATE: begin
        next_out = {next_addr, next_lastIdx};
        next_oe = 1'b1;
        next_strobe_n = 1'b0;
        next_lanes_n = ~pickLanes(next_bes, 2'd0);
      end
      lbcs_pkg::DATA_PHASE_STATE, lbcs_pkg::WAIT_PHASE_STATE: begin
        next_out = next_wdata[{next_wordIdx, 5'd0} +: 32];
        next_oe = next_isWrite;
        next_den_n = 1'b0;
        next_lanes_n = ~pickLanes(next_bes, next_wordIdx);
        // A new strobe marks each burst word that follows a completed one.
        next_strobe_n = !(state != lbcs_pkg::ADDRESS_PHASE_STATE && wordDone);
      end
      default: begin
        next_out = '0;
      end
    endcase
  end

  // Registers only. Reset is synchronous and parks every pin at its inactive
  // level, with the bus idle and ready for the first request.
  always_ff @(posedge core_clk) begin
    if (srst) begin
      state <= lbcs_pkg::IDLE_STATE;
      wordIdx <= 2'd0;
      lastIdx <= 2'd0;
      isWrite <= 1'b0;
      addr <= '0;
      bes <= '0;
      wdata <= '0;
      sharedAddrDataOut <= '0;
      sharedAddrDataOe <= 1'b0;
      addressStrobe_n <= `LBCS_STROBE_IDLE;
      byteLaneEnable_n <= `LBCS_LANES_IDLE;
      dataEnable_n <= 1'b1;
      writeNotRead <= 1'b0;
      busState <= 3'd0;
      reqReady <= 1'b1;
    end else begin
      state <= next_state;
      wordIdx <= next_wordIdx;
      lastIdx <= next_lastIdx;
      isWrite <= next_isWrite;
      addr <= next_addr;
      bes <= next_bes;
      wdata <= next_wdata;
      sharedAddrDataOut <= next_out;
      sharedAddrDataOe <= next_oe;
      addressStrobe_n <= next_strobe_n;
      byteLaneEnable_n <= next_lanes_n;
      dataEnable_n <= next_den_n;
      writeNotRead <= next_isWrite;
      busState <= next_state;
      reqReady <= next_reqReady;
    end
  end

  // Read words leave through a two-entry buffer, so one stalled cycle of the
  // consumer never costs a word that the bus has already moved.

  lbcs_skid_buffer #(
    .WIDTH(32)
  ) u_readBuffer (
    .core_clk(core_clk),
    .srst(srst),
    .inValid(pushRead),
    .inReady(bufReady),
    .inData(sharedAddrDataIn),
    .outValid(rdValid),
    .outReady(rdReady),
    .outData(rdData)
  );
endmodule

/* File: rtl/lbcs_skid_buffer.sv */
// Two-entry buffer: the sender side ready depends only on occupancy, so no word is
// lost when the receiver stalls.
module lbcs_skid_buffer #(
  parameter int WIDTH = 32
) (
  input wire logic core_clk,
  input wire logic srst,
  input wire logic inValid,
  output logic inReady,
  input wire logic [WIDTH-1:0] inData,
  output logic outValid,
  input wire logic outReady,
  output logic [WIDTH-1:0] outData
);
  logic [WIDTH-1:0] slot [2];
  logic [1:0] count;
  logic [1:0] next_count;
  logic [WIDTH-1:0] next_slot0;
  logic [WIDTH-1:0] next_slot1;
  logic doPush;
  logic doPop;
  logic validReg;

  // Elaboration refuses a width that the slots cannot hold.
  if (WIDTH < 1) begin : g_widthCheck
    $error("lbcs_skid_buffer: WIDTH must be positive.");
  end

  // Occupancy and slot shifting; slot 0 is always the head.
  always_comb begin
    doPush = inValid && (count != 2'd2);
    doPop = (count != 2'd0) && outReady;
    next_count = count;
    next_slot0 = slot[0];
    next_slot1 = slot[1];
    if (doPush && !doPop) begin
      next_count = count + 2'd1;
    end else if (doPop && !doPush) begin
      next_count = count - 2'd1;
    end
    if (doPop) begin
      next_slot0 = slot[1];
    end
    if (doPush) begin
      if (next_count == 2'd1 || (doPop && count == 2'd1)) begin
        next_slot0 = inData;
      end else begin
        next_slot1 = inData;
      end
    end
  end

  // Registers only.
  always_ff @(posedge core_clk) begin
    if (srst) begin
      count <= 2'd0;
      validReg <= 1'b0;
      slot[0] <= '0;
      slot[1] <= '0;
    end else begin
      count <= next_count;
      validReg <= (next_count != 2'd0);
      slot[0] <= next_slot0;
      slot[1] <= next_slot1;
    end
  end

  assign inReady = (count != 2'd2);
  // Valid has a flop of its own so that the port is registered; it always equals count != 0.
  assign outValid = validReg;
  assign outData = slot[0];
endmodule

/* File: tb/lbcs_mem_model.sv */
module lbcs_mem_model (
  input wire logic core_clk,
  input wire logic [3:0] waitCycles,
  input wire logic [31:0] sharedAddrDataOut,
  input wire logic addressStrobe_n,
  input wire logic [3:0] byteLaneEnable_n,
  input wire logic writeNotRead,
  input wire logic dataEnable_n,
  output logic ready_n,
  output logic [31:0] sharedAddrDataIn
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [31:0] mem [16];
  logic [31:0] last = 32'h0;
  logic [3:0] base, idx, cnt, w;
  logic [1:0] rowAddr, colAddr;
  logic nextWord, ioRead, ioWrite;
  // A strobe inside the data phase starts the next burst word.
  assign nextWord = !addressStrobe_n && !dataEnable_n;
  // A burst steps the whole word index, so a carry out of the column also steps the row.
  assign w = base + idx + {3'h0, nextWord};
  // Row and column halves of the word index, as a dynamic memory would take them.
  assign rowAddr = w[3:2];
  assign colAddr = w[1:0];
  // Separate read and write commands from the write/read line.
  assign ioRead = !dataEnable_n && !writeNotRead;
  assign ioWrite = !dataEnable_n && writeNotRead;
  assign ready_n = !(!dataEnable_n && (nextWord ? 4'h0 : cnt) >= waitCycles);
  // Released lines toggle so a stale word is never mistaken for data.
  assign sharedAddrDataIn = ioRead ? mem[{rowAddr, colAddr}] : ~last;
  initial for (int i = 0; i < 16; i++) mem[i] = 32'h5a5a0000 | i;
  // Address capture, wait counting and lane-masked writes.
  always @(posedge core_clk) begin
    last <= sharedAddrDataIn;
    if (!addressStrobe_n && dataEnable_n) begin
      base <= sharedAddrDataOut[5:2];
      idx <= 4'h0;
      cnt <= 4'h0;
    end else if (!dataEnable_n) begin
      idx <= w - base;
      cnt <= nextWord ? 4'h1 : cnt + 4'h1;
      if (!ready_n && ioWrite)
        for (int h = 0; h < 2; h++)
          for (int b = 2 * h; b < 2 * h + 2; b++)
            if (!byteLaneEnable_n[b])
              mem[{rowAddr, colAddr}][8*b+:8] <= sharedAddrDataOut[8*b+:8];
    end
  end
endmodule

/* File: tb/lbcs_seq_props.sv */
module lbcs_seq_props (
  input wire logic core_clk,
  input wire logic srst,
  input wire logic reqValid,
  input wire logic reqReady,
  input wire logic [29:0] reqWordAddr,
  input wire logic [1:0] reqSizeCode,
  input wire logic [31:0] sharedAddrDataOut,
  input wire logic sharedAddrDataOe,
  input wire logic addressStrobe_n,
  input wire logic ready_n,
  input wire logic [2:0] busState
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (srst);
  // Bus state sequencing, all one clock domain.
  idle_hold_a:
    assert property (busState == 3'h0 && !reqValid |=> busState == 3'h0) else $error("left idle");
  take_addr_a:
    assert property (reqValid && reqReady |=> busState == 3'h1) else $error("no address state");
  addr_from_a:
    assert property (busState == 3'h1 |-> $past(busState) inside {3'h0, 3'h4})
    else $error("bad address entry");
  addr_pins_a:
    assert property (busState == 3'h1 |-> !addressStrobe_n && sharedAddrDataOe)
    else $error("address pins idle");
  addr_field_a:
    assert property (busState == 3'h1 |->
      sharedAddrDataOut == {$past(reqWordAddr), $past(reqSizeCode)}) else $error("bad address");
  addr_exit_a:
    assert property (busState == 3'h1 |=> busState inside {3'h2, 3'h3}) else $error("no data");
  wait_hold_a:
    assert property (busState inside {3'h2, 3'h3} && ready_n |=> busState == 3'h3)
    else $error("moved without ready");
  rec_idle_a:
    assert property (busState == 3'h4 && !reqValid |=> busState == 3'h0) else $error("no idle");
  rec_entry_a:
    assert property (busState == 3'h4 |-> $past(busState) inside {3'h2, 3'h3})
    else $error("recovery without data");
  strobe_burst_a:
    assert property (busState == 3'h2 && $past(busState) inside {3'h2, 3'h3}
      |-> !addressStrobe_n) else $error("burst word without strobe");
  strobe_wait_a:
    assert property (busState == 3'h3 |-> addressStrobe_n) else $error("strobe in wait state");
endmodule

bind lbcs_sequencer lbcs_seq_props u_props (.core_clk, .srst, .reqValid, .reqReady,
  .reqWordAddr, .reqSizeCode, .sharedAddrDataOut, .sharedAddrDataOe, .addressStrobe_n,
  .ready_n, .busState);

/* File: tb/tb_local_bus_cycle_sequencer.sv */
module tb_local_bus_cycle_sequencer;
  timeunit 1ns;
  timeprecision 1ns;
  logic core_clk, srst, reqValid, reqReady, reqWrite, rdValid, rdReady, sharedAddrDataOe;
  logic addressStrobe_n, writeNotRead, dataEnable_n, ready_n;
  logic [29:0] reqWordAddr;
  logic [1:0] reqSizeCode;
  logic [15:0] reqByteEnables;
  logic [127:0] reqWriteData;
  logic [31:0] rdData, sharedAddrDataIn, sharedAddrDataOut;
  logic [3:0] byteLaneEnable_n, waitCycles;
  logic [2:0] busState, lastSt;
  logic [31:0] model [16];
  logic [31:0] rq [$];
  int fails = 0;
  int cmp_count = 0;
  int waits;
  lbcs_sequencer dut_u (.core_clk, .srst, .reqValid, .reqReady, .reqWrite, .reqWordAddr,
    .reqSizeCode, .reqByteEnables, .reqWriteData, .rdValid, .rdReady, .rdData,
    .sharedAddrDataIn, .sharedAddrDataOut, .sharedAddrDataOe, .addressStrobe_n,
    .byteLaneEnable_n, .writeNotRead, .dataEnable_n, .ready_n, .busState);
  lbcs_mem_model mem_u (.core_clk, .waitCycles, .sharedAddrDataOut, .addressStrobe_n,
    .byteLaneEnable_n, .writeNotRead, .dataEnable_n, .ready_n, .sharedAddrDataIn);
  // Clock at 10 MHz.
  initial begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end
  // Collect every read word handed over at the buffer output.
  always @(posedge core_clk) if (rdValid === 1'b1 && rdReady === 1'b1) rq.push_back(rdData);
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // The request is held until the edge that takes it.
  task automatic req(input logic wr, input int a, input int n, input logic [15:0] lanes,
      input logic [127:0] d);
    @(posedge core_clk);
    reqValid <= 1'b1;
    reqWrite <= wr;
    reqWordAddr <= 30'(a);
    reqSizeCode <= 2'(n - 1);
    reqByteEnables <= lanes;
    reqWriteData <= d;
    @(negedge core_clk);
    for (int k = 0; k < 50 && reqReady !== 1'b1; k++) @(negedge core_clk);
    chk({31'h0, reqReady}, 32'h1);
    lastSt = busState;
    @(posedge core_clk);
    reqValid <= 1'b0;
    if (wr)
      for (int i = 0; i < n; i++)
        for (int b = 0; b < 4; b++)
          if (lanes[4*i+b]) model[a+i][8*b+:8] = d[32*i+8*b+:8];
  endtask
  task automatic idle_wait;
    waits = 0;
    @(negedge core_clk);
    for (int k = 0; k < 300 && busState !== 3'h0; k++) begin
      if (busState === 3'h3) waits++;
      @(negedge core_clk);
    end
    chk({29'h0, busState}, 32'h0);
  endtask
  // Read back n words, optionally with the consumer stalled meanwhile.
  task automatic read_chk(input int a, input int n, input bit st);
    if (st) begin
      @(posedge core_clk);
      rdReady <= 1'b0;
    end
    req(1'b0, a, n, 16'hffff, 128'h0);
    if (st) begin
      repeat (20) @(negedge core_clk);
      chk({29'h0, busState}, 32'h3);
      @(posedge core_clk);
      rdReady <= 1'b1;
    end
    idle_wait;
    repeat (3) @(negedge core_clk);
    chk(32'(rq.size()), 32'(n));
    for (int i = 0; i < n; i++) chk(rq.pop_front(), model[a+i]);
  endtask
  task automatic t_sizes;
    for (int s = 1; s <= 4; s++) read_chk(s, s, 1'b0);
  endtask
  task automatic t_write;
    req(1'b1, 4, 4, 16'hff6f, {32'hc0de0003, 32'hc0de0002, 32'hc0de0001, 32'hc0de0000});
    idle_wait;
    read_chk(4, 4, 1'b0);
  endtask
  task automatic t_slow;
    @(posedge core_clk);
    waitCycles <= 4'h3;
    read_chk(9, 2, 1'b0);
    chk(32'(waits), 32'h6);
    @(posedge core_clk);
    waitCycles <= 4'h0;
  endtask
  task automatic t_b2b;
    req(1'b1, 12, 1, 16'h000f, 128'h1234abcd);
    req(1'b1, 13, 1, 16'h000c, 128'h5678ef01);
    chk({29'h0, lastSt}, 32'h4);
    idle_wait;
    read_chk(12, 4, 1'b1);
  endtask
  task automatic results;
    $display("comparisons %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // Main sequence after a five-cycle reset.
  initial begin
    srst = 1'b1;
    reqValid = 1'b0;
    reqWrite = 1'b0;
    reqWordAddr = 30'h0;
    reqSizeCode = 2'h0;
    reqByteEnables = 16'h0;
    reqWriteData = 128'h0;
    rdReady = 1'b1;
    waitCycles = 4'h0;
    for (int i = 0; i < 16; i++) model[i] = 32'h5a5a0000 | i;
    repeat (5) @(posedge core_clk);
    srst <= 1'b0;
    t_sizes;
    t_write;
    t_slow;
    t_b2b;
    results;
  end
  // A hang is cut short well past the expected run length.
  initial begin
    #2000000;
    fails++;
    results;
  end
endmodule
